// >>> rtl/pevf_cfg.svh
// constants for the peripheral event flag block
`ifndef PEVF_CFG_SVH
`define PEVF_CFG_SVH
`define PEVF_ADDR_W        4
`define PEVF_ADDR_FLAGS    4'h0
`define PEVF_ADDR_MASK     4'h1
`define PEVF_ADDR_STATUS   4'h2
`define PEVF_BIT_PSP       7
`define PEVF_BIT_ADC       6
`define PEVF_BIT_RX        5
`define PEVF_BIT_TX        4
`define PEVF_BIT_SSP       3
`define PEVF_FLAGS_RST     8'h00
`define PEVF_MASK_RST      8'h00
`define PEVF_ZERO8         8'h00
`define PEVF_STICKY_MASK   8'hc8
`define PEVF_LEVEL_MASK    8'h30
`define PEVF_FLAG_W_MASK   8'hc8
`endif

// >>> rtl/pevf_pkg.sv
// types for the peripheral event flag block
package pevf_pkg;
  typedef struct packed {
    logic psp_done;
    logic adc_done;
    logic rx_full;
    logic tx_empty;
    logic ssp_done;
  } pevf_events_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pevf_bus_t;
endpackage

// >>> rtl/pevf_sticky.sv
// one sticky flag bit, set wins over clear
`timescale 1ns/1ns
`default_nettype none
module pevf_sticky (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic set_in,
  input  wire logic clr_in,
  output logic      q
);
  typedef struct packed {
    logic q;
  } pevf_sticky_state_t;
  pevf_sticky_state_t s_reg;
  pevf_sticky_state_t s_next;
  always_comb begin
    s_next = s_reg;
    if (clr_in) begin
      s_next.q = 1'b0;
    end
    if (set_in) begin
      s_next.q = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign q = s_reg.q;
endmodule
`default_nettype wire

// >>> rtl/pevf_top.sv
// peripheral event flag register with interrupt status and mask
//
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "pevf_cfg.svh"
module pevf_top (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire pevf_pkg::pevf_bus_t   bus,
  input  wire pevf_pkg::pevf_events_t ev,
  output logic [7:0]                 rdata,
  output logic [7:0]                 peripheral_event_flags,
  output logic                       irq
);
  import pevf_pkg::*;

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] status;
    logic [7:0] rdata;
    logic       rx_prev;
    logic       tx_prev;
  } pevf_state_t;

  pevf_state_t s_reg;
  pevf_state_t s_next;
  logic [7:0]  flags;
  logic [7:0]  sticky_q;
  logic [7:0]  st_set;
  logic [7:0]  set_vec;
  logic [7:0]  clr_vec;
  logic [7:0]  rd_word;
  logic [7:0]  pend;
  logic        wr_flags;
  logic        wr_mask;
  logic        rd_flags;
  logic        rd_mask;
  logic        rd_status;
  logic        rd_unmapped;
  logic        rx_rise;
  logic        tx_rise;
  logic        psp_q;
  logic        adc_q;
  logic        ssp_q;

  // register decode from the strobes
  always_comb begin
    wr_flags    = 1'b0;
    wr_mask     = 1'b0;
    rd_flags    = 1'b0;
    rd_mask     = 1'b0;
    rd_status   = 1'b0;
    rd_unmapped = 1'b0;
    if (bus.wr) begin
      unique case (bus.addr)
        `PEVF_ADDR_FLAGS: begin
          wr_flags = 1'b1;
        end
        `PEVF_ADDR_MASK: begin
          wr_mask = 1'b1;
        end
        default: begin
          // status and unmapped writes are ignored
          wr_mask = 1'b0;
        end
      endcase
    end
    if (bus.rd) begin
      unique case (bus.addr)
        `PEVF_ADDR_FLAGS: begin
          rd_flags = 1'b1;
        end
        `PEVF_ADDR_MASK: begin
          rd_mask = 1'b1;
        end
        `PEVF_ADDR_STATUS: begin
          rd_status = 1'b1;
        end
        default: begin
          rd_unmapped = 1'b1;
        end
      endcase
    end
  end

  // sticky set sources
  always_comb begin
    set_vec = `PEVF_ZERO8;
    set_vec[`PEVF_BIT_PSP] = ev.psp_done;
    set_vec[`PEVF_BIT_ADC] = ev.adc_done;
    set_vec[`PEVF_BIT_SSP] = ev.ssp_done;
  end

  // write of zero clears, write of one keeps
  always_comb begin
    clr_vec = `PEVF_ZERO8;
    if (wr_flags) begin
      clr_vec = ~bus.wdata & `PEVF_STICKY_MASK;
    end
  end

  // sticky flags, set wins over clear
  pevf_sticky u_psp (
    .mclk   (mclk),
    .rst    (rst),
    .set_in (set_vec[`PEVF_BIT_PSP]),
    .clr_in (clr_vec[`PEVF_BIT_PSP]),
    .q      (psp_q)
  );
  pevf_sticky u_adc (
    .mclk   (mclk),
    .rst    (rst),
    .set_in (set_vec[`PEVF_BIT_ADC]),
    .clr_in (clr_vec[`PEVF_BIT_ADC]),
    .q      (adc_q)
  );
  pevf_sticky u_ssp (
    .mclk   (mclk),
    .rst    (rst),
    .set_in (set_vec[`PEVF_BIT_SSP]),
    .clr_in (clr_vec[`PEVF_BIT_SSP]),
    .q      (ssp_q)
  );

  // sticky bits in register positions
  always_comb begin
    sticky_q = `PEVF_ZERO8;
    sticky_q[`PEVF_BIT_PSP] = psp_q;
    sticky_q[`PEVF_BIT_ADC] = adc_q;
    sticky_q[`PEVF_BIT_SSP] = ssp_q;
  end

  // live flag view, level flags pass straight through
  always_comb begin
    flags = sticky_q;
    flags[`PEVF_BIT_RX] = ev.rx_full;
    flags[`PEVF_BIT_TX] = ev.tx_empty;
  end

  // rising edges of the level flags
  assign rx_rise = ev.rx_full && !s_reg.rx_prev;
  assign tx_rise = ev.tx_empty && !s_reg.tx_prev;

  // status set sources
  always_comb begin
    st_set = `PEVF_ZERO8;
    st_set[`PEVF_BIT_PSP] = ev.psp_done;
    st_set[`PEVF_BIT_ADC] = ev.adc_done;
    st_set[`PEVF_BIT_SSP] = ev.ssp_done;
    st_set[`PEVF_BIT_RX]  = rx_rise;
    st_set[`PEVF_BIT_TX]  = tx_rise;
  end

  // read data for the cycle after the strobe
  always_comb begin
    rd_word = `PEVF_ZERO8;
    if (rd_flags) begin
      rd_word = flags;
    end
    if (rd_mask) begin
      rd_word = s_reg.mask;
    end
    if (rd_status) begin
      rd_word = s_reg.status;
    end
    if (rd_unmapped) begin
      // unmapped addresses read zero
      rd_word = `PEVF_ZERO8;
    end
  end

  // next state: mask, read data, status
  always_comb begin
    s_next = s_reg;
    s_next.rx_prev = ev.rx_full;
    s_next.tx_prev = ev.tx_empty;
    s_next.rdata = rd_word;
    if (wr_mask) begin
      s_next.mask = bus.wdata;
    end
    if (rd_status) begin
      s_next.status = `PEVF_ZERO8;
    end
    // an event in the clearing cycle still lands
    if (|st_set) begin
      s_next.status = s_next.status | st_set;
    end
  end

  // registers, synchronous reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_reg.mask    <= `PEVF_MASK_RST;
      s_reg.status  <= `PEVF_ZERO8;
      s_reg.rdata   <= `PEVF_ZERO8;
      // inputs seed the edge detect, no false edge at release
      s_reg.rx_prev <= ev.rx_full;
      s_reg.tx_prev <= ev.tx_empty;
    end else begin
      s_reg <= s_next;
    end
  end

  // pending events after the mask
  always_comb begin
    pend = s_reg.status & s_reg.mask;
  end

  // outputs
  assign rdata = s_reg.rdata;
  assign peripheral_event_flags = flags;
  assign irq = |pend;
endmodule
`default_nettype wire

// >>> tb/pevf_asserts.sv
// assertions for the peripheral event flag block
`timescale 1ns/1ns
`default_nettype none
module pevf_asserts (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire pevf_pkg::pevf_bus_t    bus,
  input wire pevf_pkg::pevf_events_t ev,
  input wire logic [7:0]             rdata,
  input wire logic [7:0]             peripheral_event_flags,
  input wire logic                   irq
);
  import pevf_pkg::*;
  wire [7:0] f = peripheral_event_flags;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_PSP_SET: assert property (ev.psp_done |=> f[7])
    else $error("port flag not set");
  AST_RX_LIVE: assert property (f[5] == ev.rx_full)
    else $error("rx flag wrong");
  AST_TX_LIVE: assert property (f[4] == ev.tx_empty)
    else $error("tx flag wrong");
  AST_SSP_SET: assert property (ev.ssp_done |=> f[3])
    else $error("sync flag not set");
  AST_ADC_CAUSE: assert property ($rose(f[6]) |-> $past(ev.adc_done))
    else $error("adc flag without event");
  AST_ADC_ANY: assert property (ev.adc_done |=> f[6])
    else $error("adc flag not set");
  cover property (irq);
  cover property (bus.rd && bus.addr == 4'h2);
  cover property (ev.psp_done);
endmodule
bind pevf_top pevf_asserts u_chk (.mclk, .rst, .bus, .ev, .rdata,
  .peripheral_event_flags, .irq);
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the peripheral event flag block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pevf_pkg::*;
  logic         mclk;
  logic         rst;
  pevf_bus_t    bus;
  pevf_events_t ev;
  logic [7:0]   rdata;
  logic [7:0]   flags;
  logic         irq;
  int           num_errors = 0;
  int           n_compared = 0;
  pevf_top u_dut (.mclk, .rst, .bus, .ev, .rdata,
    .peripheral_event_flags(flags), .irq);
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) bus.wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk) bus.rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  task pulse(input pevf_events_t p);
    @(posedge mclk) ev <= ev | p;
    @(posedge mclk) ev <= ev & ~p;
    #1;
  endtask
  task finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge mclk);
    num_errors++;
    finish_test;
  end
  initial begin
    bus = '0;
    ev = 5'h02;
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(4'h0, 8'hff, 8'h10);
    pulse(5'h19);
    chk(flags, 8'hd8);
    chk({7'h00, irq}, 8'h00);
    wr(4'h1, 8'hff);
    chk({7'h00, irq}, 8'h01);
    rd(4'h1, 8'hff, 8'hff);
    rd(4'h2, 8'hff, 8'hc8);
    chk({7'h00, irq}, 8'h00);
    wr(4'h0, 8'hff);
    chk(flags, 8'hd8);
    wr(4'h0, 8'h00);
    chk(flags, 8'h10);
    @(posedge mclk) ev <= 5'h04;
    #1 chk(flags & 8'h20, 8'h20);
    chk(flags & 8'h10, 8'h00);
    rd(4'h2, 8'hff, 8'h20);
    rd(4'hf, 8'hff, 8'h00);
    @(posedge mclk) ev <= 5'h02;
    rd(4'h2, 8'hff, 8'h10);
    finish_test;
  end
endmodule
`default_nettype wire
